// *** logic/cal_datapath.sv ***
// offset then gain correction for each channel
`timescale 1ns/100ps
`include "cal_defs.svh"
module cal_datapath
	import cal_pkg::*;
(
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// link to the register bank
	cal_if.path       link
);
	// ------------------------------------------------------------------
	// valid pipeline
	// ------------------------------------------------------------------
	logic sum_valid;    // offset stage holds data

	// two stages, valid follows the data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sum_valid      <= 1'b0;
			link.out_valid <= 1'b0;
		end else begin
			sum_valid      <= link.in_valid;
			link.out_valid <= sum_valid;
		end
	end

	// ------------------------------------------------------------------
	// per channel arithmetic
	// ------------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			logic signed [24:0] sum;       // sample plus offset, one guard bit
			logic signed [49:0] product;   // sum times gain fraction
			logic signed [49:0] scaled;    // product back to sample scale
			logic signed [23:0] limited;   // saturated result

			// offset first, one bit wider so it cannot wrap
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sum <= 25'sh0;
				end else if (link.in_valid) begin
					sum <= 25'(link.sample_in[ch]) + 25'(link.offset[ch]); // [RULE8]
				end
			end

			// gain as unsigned fraction, unity at the top bit
			always_comb begin
				product = 50'(sum) * $signed({26'h0, link.gain[ch]}); // [RULE8]
				scaled  = product >>> `GAIN_FRACTION_BITS;
				if (scaled > 50'sh7fffff) begin
					limited = 24'sh7fffff;
				end else if (scaled < -50'sh800000) begin
					limited = -24'sh800000;
				end else begin
					limited = scaled[23:0];
				end
			end

			// calibrated output register
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					link.sample_out[ch] <= 24'sh0;
				end else if (sum_valid) begin
					link.sample_out[ch] <= limited;
				end
			end
		end
	endgenerate
endmodule

// *** logic/cal_defs.svh ***
// constants for the channel calibration register slice
//
// Operation
// (RULE1) offset upper sixteen bits, read/write, reset zero
// (RULE2) offset low byte in bits 15:8
// (RULE3) gain upper sixteen bits, reset 8000h
// (RULE4) gain low byte bits 15:8, low byte zero
// (RULE5) ten-bit signed phase delay, bits 15:6
// (RULE6) bit 2 turns channel dc block off
// (RULE7) bits 1:0 select channel input source
// (RULE8) samples get offset then fractional gain
`ifndef CAL_DEFS_SVH
`define CAL_DEFS_SVH

// ------------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define IDX_CH1_OFFSET_HIGH 6'h0f
`define IDX_CH1_OFFSET_LOW  6'h10
`define IDX_CH1_GAIN_HIGH   6'h11
`define IDX_CH1_GAIN_LOW    6'h12
`define IDX_CH2_CONFIG      6'h13
`define IDX_CH2_OFFSET_HIGH 6'h14
`define IDX_CH2_OFFSET_LOW  6'h15

// ------------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------------
`define LOW_FIELD_MSB       15
`define LOW_FIELD_LSB       8
`define PHASE_MSB           15
`define PHASE_LSB           6
`define DC_OFF_BIT          2
`define SELECT_MSB          1
`define SELECT_LSB          0
`define OFFSET_HIGH_RESET   16'h0000
`define LOW_BYTE_RESET      8'h00
`define GAIN_HIGH_RESET     16'h8000
`define PHASE_RESET         10'h000
`define UNITY_GAIN          24'h800000
`define GAIN_FRACTION_BITS  23

// ------------------------------------------------------------------
// bus answers
// ------------------------------------------------------------------
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// *** logic/cal_if.sv ***
// carrier between the register bank and the calibration datapath
`timescale 1ns/100ps
interface cal_if;
	import cal_pkg::*;
	cal_pair_t  offset;       // offset per channel
	gain_pair_t gain;         // gain per channel
	cal_pair_t  sample_in;    // raw samples
	logic       in_valid;     // raw samples present
	cal_pair_t  sample_out;   // calibrated samples
	logic       out_valid;    // calibrated samples present

	modport bank (output offset, output gain, output sample_in, output in_valid,
		input sample_out, input out_valid);
	modport path (input offset, input gain, input sample_in, input in_valid,
		output sample_out, output out_valid);
endinterface

// *** logic/cal_pkg.sv ***
// types shared by the calibration register slice
package cal_pkg;
	typedef logic signed [23:0] cal_word_t;        // one calibrated or raw sample
	typedef logic [23:0]        gain_word_t;       // unsigned gain fraction
	typedef cal_word_t [1:0]    cal_pair_t;        // one word per channel
	typedef gain_word_t [1:0]   gain_pair_t;       // one gain per channel
	typedef enum logic [1:0] {
		SEL_OWN_PINS  = 2'h0,
		SEL_SHORTED   = 2'h1,
		SEL_TEST_POS  = 2'h2,
		SEL_TEST_NEG  = 2'h3
	} input_select_t;
endpackage

// *** logic/cal_regs.sv ***
// channel calibration register bank with axi4-lite slave
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "cal_defs.svh"
module cal_regs
	import cal_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output var  logic              awready,
	// axi4-lite write data
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	// axi4-lite write response
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output var  logic              arready,
	// axi4-lite read data
	output var  logic [31:0]       rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready,
	// raw samples from the converter and the global dc filter setting
	input  wire logic [23:0]       ch1_sample_in,
	input  wire logic [23:0]       ch2_sample_in,
	input  wire logic              sample_in_valid,
	input  wire logic [3:0]        global_dc_filter_setting,
	// calibrated samples
	output var  logic [23:0]       ch1_sample_out,
	output var  logic [23:0]       ch2_sample_out,
	output var  logic              sample_out_valid,
	// channel 2 configuration
	output var  logic [9:0]        ch2_phase_delay,
	output var  logic              ch2_dc_block_off,
	output var  logic              ch2_dc_block_active,
	output var  input_select_t     ch2_input_select
);
	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	logic [15:0] ch1_offset_upper_field;   // offset bits 23:8
	logic [7:0]  ch1_offset_lower_field;   // offset bits 7:0
	logic [15:0] ch1_gain_upper_field;     // gain bits 23:8
	logic [7:0]  ch1_gain_lower_field;     // gain bits 7:0
	logic [15:0] ch2_offset_upper_field;   // offset bits 23:8
	logic [7:0]  ch2_offset_lower_field;   // offset bits 7:0

	// ------------------------------------------------------------------
	// bus handshake state
	// ------------------------------------------------------------------
	logic              aw_held;        // write address captured
	logic              w_held;         // write data captured
	logic [5:0]        wr_index;       // captured word index
	logic              wr_aligned;     // captured address low bits zero
	logic [15:0]       wr_value;       // captured low half of data
	logic [1:0]        wr_lanes;       // captured low byte enables
	logic              do_write;       // both halves present, answer free
	logic              next_aw_held;   // address hold next cycle
	logic              next_w_held;    // data hold next cycle
	logic              next_rvalid;    // read answer next cycle
	logic              wr_hit;         // address aligned and index names a register

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// true for any index that maps to a register
	function automatic logic index_mapped(input logic [5:0] idx);
		return idx >= `IDX_CH1_OFFSET_HIGH && idx <= `IDX_CH2_OFFSET_LOW;
	endfunction

	// merge enabled byte lanes into a 16-bit field
	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] val,
		input logic [1:0] lanes);
		return {lanes[1] ? val[15:8] : old[15:8], lanes[0] ? val[7:0] : old[7:0]};
	endfunction

	// register content seen by software
	function automatic logic [15:0] read_word(input logic [5:0] idx);
		case (idx)
			`IDX_CH1_OFFSET_HIGH: read_word = ch1_offset_upper_field;                  // [RULE1]
			`IDX_CH1_OFFSET_LOW:  read_word = {ch1_offset_lower_field, 8'h00};        // [RULE2]
			`IDX_CH1_GAIN_HIGH:   read_word = ch1_gain_upper_field;                    // [RULE3]
			`IDX_CH1_GAIN_LOW:    read_word = {ch1_gain_lower_field, 8'h00};          // [RULE4]
			`IDX_CH2_CONFIG:      read_word = {ch2_phase_delay, 3'h0, ch2_dc_block_off,
				ch2_input_select};                                                 // [RULE5]
			`IDX_CH2_OFFSET_HIGH: read_word = ch2_offset_upper_field;                  // [RULE1]
			`IDX_CH2_OFFSET_LOW:  read_word = {ch2_offset_lower_field, 8'h00};        // [RULE2]
			default:              read_word = 16'h0000;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// write channel
	// ------------------------------------------------------------------
	assign do_write     = aw_held && w_held && !bvalid;
	assign wr_hit       = wr_aligned && index_mapped(wr_index);
	assign next_aw_held = do_write ? 1'b0 : ((awvalid && awready) ? 1'b1 : aw_held);
	assign next_w_held  = do_write ? 1'b0 : ((wvalid && wready) ? 1'b1 : w_held);

	// address capture, ready drops while one is held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held    <= 1'b0;
			awready    <= 1'b0;
			wr_index   <= 6'h00;
			wr_aligned <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			awready <= !next_aw_held;
			if (awvalid && awready) begin
				wr_index   <= awaddr[7:2];
				wr_aligned <= awaddr[1:0] == 2'h0;
			end
		end
	end

	// data capture, independent of the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held   <= 1'b0;
			wready   <= 1'b0;
			wr_value <= 16'h0000;
			wr_lanes <= 2'h0;
		end else begin
			w_held <= next_w_held;
			wready <= !next_w_held;
			if (wvalid && wready) begin
				wr_value <= wdata[15:0];
				wr_lanes <= wstrb[1:0];
			end
		end
	end

	// write answer, error for unmapped or misaligned
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// register updates
	// ------------------------------------------------------------------
	// offset and gain storage, reserved low bytes never stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ch1_offset_upper_field <= `OFFSET_HIGH_RESET;  // [RULE1]
			ch1_offset_lower_field <= `LOW_BYTE_RESET;     // [RULE2]
			ch1_gain_upper_field   <= `GAIN_HIGH_RESET;    // [RULE3]
			ch1_gain_lower_field   <= `LOW_BYTE_RESET;     // [RULE4]
			ch2_offset_upper_field <= `OFFSET_HIGH_RESET;  // [RULE1]
			ch2_offset_lower_field <= `LOW_BYTE_RESET;     // [RULE2]
		end else if (do_write && wr_hit) begin
			case (wr_index)
				`IDX_CH1_OFFSET_HIGH: ch1_offset_upper_field <=
					lane_merge(ch1_offset_upper_field, wr_value, wr_lanes);           // [RULE1]
				`IDX_CH1_OFFSET_LOW: if (wr_lanes[1]) begin
					ch1_offset_lower_field <= wr_value[`LOW_FIELD_MSB:`LOW_FIELD_LSB]; // [RULE2]
				end
				`IDX_CH1_GAIN_HIGH: ch1_gain_upper_field <=
					lane_merge(ch1_gain_upper_field, wr_value, wr_lanes);             // [RULE3]
				`IDX_CH1_GAIN_LOW: if (wr_lanes[1]) begin
					ch1_gain_lower_field <= wr_value[`LOW_FIELD_MSB:`LOW_FIELD_LSB];   // [RULE4]
				end
				`IDX_CH2_OFFSET_HIGH: ch2_offset_upper_field <=
					lane_merge(ch2_offset_upper_field, wr_value, wr_lanes);           // [RULE1]
				`IDX_CH2_OFFSET_LOW: if (wr_lanes[1]) begin
					ch2_offset_lower_field <= wr_value[`LOW_FIELD_MSB:`LOW_FIELD_LSB]; // [RULE2]
				end
				default: begin
				end
			endcase
		end
	end

	// channel 2 configuration word, reserved bits 5:3 not stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ch2_phase_delay  <= `PHASE_RESET;
			ch2_dc_block_off <= 1'b0;
			ch2_input_select <= SEL_OWN_PINS;
		end else if (do_write && wr_hit && wr_index == `IDX_CH2_CONFIG) begin
			if (wr_lanes[1]) begin
				ch2_phase_delay[9:2] <= wr_value[`PHASE_MSB:8];                           // [RULE5]
			end
			if (wr_lanes[0]) begin
				ch2_phase_delay[1:0] <= wr_value[7:`PHASE_LSB];                           // [RULE5]
				ch2_dc_block_off     <= wr_value[`DC_OFF_BIT];                            // [RULE6]
				ch2_input_select     <= input_select_t'(wr_value[`SELECT_MSB:`SELECT_LSB]); // [RULE7]
			end
		end
	end

	// channel follows the global filter unless switched off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ch2_dc_block_active <= 1'b0;
		end else begin
			ch2_dc_block_active <= !ch2_dc_block_off && (global_dc_filter_setting != 4'h0); // [RULE6]
		end
	end

	// ------------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------------
	assign next_rvalid = (arvalid && arready) ? 1'b1 : (rready ? 1'b0 : rvalid);

	// one read in flight, answer the cycle after it is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid  <= 1'b0;
			arready <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= `RESP_OKAY;
		end else begin
			rvalid  <= next_rvalid;
			arready <= !next_rvalid;
			if (arvalid && arready) begin
				rdata <= {16'h0000, read_word(araddr[7:2])};
				rresp <= (araddr[1:0] == 2'h0 && index_mapped(araddr[7:2])) ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// ------------------------------------------------------------------
	// calibration datapath
	// ------------------------------------------------------------------
	cal_if link ();

	assign link.offset[0]    = {ch1_offset_upper_field, ch1_offset_lower_field};   // [RULE8]
	assign link.offset[1]    = {ch2_offset_upper_field, ch2_offset_lower_field};   // [RULE8]
	assign link.gain[0]      = {ch1_gain_upper_field, ch1_gain_lower_field};       // [RULE8]
	assign link.gain[1]      = `UNITY_GAIN;
	assign link.sample_in[0] = ch1_sample_in;
	assign link.sample_in[1] = ch2_sample_in;
	assign link.in_valid     = sample_in_valid;

	cal_datapath u_path (
		.aclk    (aclk),
		.aresetn (aresetn),
		.link    (link.path)
	);

	// results leave through the datapath output flops
	assign ch1_sample_out   = link.sample_out[0];
	assign ch2_sample_out   = link.sample_out[1];
	assign sample_out_valid = link.out_valid;

endmodule

// *** logic/cal_top_note.sv ***
// no logic here: the top of the calibration slice is cal_regs

// *** test/cal_checker.sv ***
// assertion checker for the calibration register bank
`timescale 1ns/100ps
module cal_checker
	import cal_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// register bus
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic [31:0]       wdata,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic              bvalid,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [31:0]       rdata,
	input wire logic              rvalid,
	// sample path and channel 2 outputs
	input wire logic              sample_in_valid,
	input wire logic              sample_out_valid,
	input wire logic [3:0]        global_dc_filter_setting,
	input wire logic [9:0]        ch2_phase_delay,
	input wire logic              ch2_dc_block_off,
	input wire logic              ch2_dc_block_active,
	input wire input_select_t     ch2_input_select
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic wr_both;  // address and data taken together
	logic wr_cfg;   // config write taken
	logic rd_cfg;   // config read taken
	logic rd_low;   // read of a low half register
	assign wr_both = awvalid && awready && wvalid && wready;
	assign wr_cfg  = wr_both && awaddr == 8'h4c;
	assign rd_cfg  = arvalid && arready && araddr == 8'h4c;
	assign rd_low  = arvalid && arready && araddr inside {8'h40, 8'h48, 8'h54};
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_write_answer: assert property (wr_both |-> ##2 bvalid)
		else $error("write answer late");
	a_low_reserved: assert property (rd_low |=> rvalid && rdata[7:0] == 8'h00)
		else $error("low byte not zero");
	a_cfg_reserved: assert property (rd_cfg |=> rdata[5:3] == 3'b000 && rdata[31:16] == 16'h0000)
		else $error("config reserved bits set");
	a_phase_follows: assert property (wr_cfg |-> ##2 ch2_phase_delay == $past(wdata[15:6], 2))
		else $error("phase delay wrong");
	a_dc_off_follows: assert property (wr_cfg |-> ##2 ch2_dc_block_off == $past(wdata[2], 2))
		else $error("dc block off wrong");
	a_select_follows: assert property (wr_cfg |-> ##2 ch2_input_select == $past(wdata[1:0], 2))
		else $error("input select wrong");
	a_cfg_reset: assert property ($rose(aresetn) |-> ch2_phase_delay == 10'h000 &&
		!ch2_dc_block_off && ch2_input_select == SEL_OWN_PINS)
		else $error("config not at reset");
	a_dc_forced_off: assert property (ch2_dc_block_off |=> !ch2_dc_block_active)
		else $error("dc block still active");
	a_dc_follows_global: assert property (!ch2_dc_block_off && global_dc_filter_setting != 4'h0
		|=> ch2_dc_block_active)
		else $error("dc block not following global");
	a_sample_answer: assert property (sample_in_valid |-> ##2 sample_out_valid)
		else $error("sample answer late");
	// main scenarios reached
	c_cfg_write: cover property (wr_cfg);
	c_low_read: cover property (rd_low);
	c_sample: cover property (sample_in_valid ##2 sample_out_valid);
endmodule

bind cal_regs cal_checker #(.ADDR_W(ADDR_W)) u_chk (.aclk, .aresetn, .awaddr, .awvalid, .awready,
	.wdata, .wvalid, .wready, .bvalid, .araddr, .arvalid, .arready, .rdata, .rvalid, .sample_in_valid,
	.sample_out_valid, .global_dc_filter_setting, .ch2_phase_delay, .ch2_dc_block_off,
	.ch2_dc_block_active, .ch2_input_select);

// *** test/host_model.sv ***
// host-side bus master model for the register bank
`timescale 1ns/100ps
module host_model (
	// clock
	input  wire logic        aclk,
	// write channels
	output var  logic [7:0]  awaddr,
	output var  logic        awvalid,
	input  wire logic        awready,
	output var  logic [31:0] wdata,
	output var  logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output var  logic        bready,
	// read channels
	output var  logic [7:0]  araddr,
	output var  logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output var  logic        rready
);
	// idle bus at time zero
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// one write: release each channel once taken, wait for the answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				done = 1;
			end
		end
	endtask
	// one read: data and code taken at the edge rvalid is seen
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1;
			end
		end
	endtask
endmodule

// *** test/tb.sv ***
// self-checking testbench for the calibration register bank
`timescale 1ns/100ps
module tb;
	import cal_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, sample_in_valid, sample_out_valid;
	logic        ch2_dc_block_off, ch2_dc_block_active;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic [3:0]  global_dc_filter_setting;
	logic [23:0] ch1_sample_in, ch2_sample_in, ch1_sample_out, ch2_sample_out;
	logic [9:0]  ch2_phase_delay;
	input_select_t ch2_input_select;
	int          error_cnt, samples_checked;
	// clock of 8 ns
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	cal_regs dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf),
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .ch1_sample_in, .ch2_sample_in, .sample_in_valid,
		.global_dc_filter_setting, .ch1_sample_out, .ch2_sample_out, .sample_out_valid,
		.ch2_phase_delay, .ch2_dc_block_off, .ch2_dc_block_active, .ch2_input_select);
	host_model host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	// ----------------------------------------
	// compare and close
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// reset values of all seven registers
	task automatic t_reset();
		logic [15:0] exp [7] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		for (int i = 0; i < 7; i++) begin
			host.rd(8'h3c + 8'(4 * i), d, r);
			chk(d, {16'h0000, exp[i]});
		end
	endtask
	// all ones written, reserved bits must stay zero
	task automatic t_mask();
		logic [15:0] exp [7] = '{16'hffff, 16'hff00, 16'hffff, 16'hff00, 16'hffc7, 16'hffff, 16'hff00};
		for (int i = 0; i < 7; i++) begin
			host.wr(8'h3c + 8'(4 * i), 32'hffff_ffff, r);
			chk(r, 2'b00);
			host.rd(8'h3c + 8'(4 * i), d, r);
			chk(d, {16'h0000, exp[i]});
		end
	endtask
	// every input select code, dc disable both ways
	task automatic t_config();
		global_dc_filter_setting <= 4'h3;
		for (int s = 0; s < 4; s++) begin
			host.wr(8'h4c, {16'h0000, 10'h200 | 10'(s), 3'b111, s[0], s[1:0]}, r);
			chk(ch2_input_select, s[1:0]);
			chk(ch2_phase_delay, 10'h200 | 10'(s));
			chk(ch2_dc_block_off, s[0]);
			@(posedge aclk);
			#1;
			chk(ch2_dc_block_active, !s[0]);
		end
	endtask
	// unmapped and misaligned places are refused
	task automatic t_refuse();
		host.wr(8'h58, 32'h0000_1234, r);
		chk(r, 2'b10);
		host.rd(8'h58, d, r);
		chk(r, 2'b10);
		chk(d, 32'h0);
		host.wr(8'h3d, 32'h0000_1234, r);
		chk(r, 2'b10);
		host.rd(8'h3c, d, r);
		chk(d, 32'h0000_ffff);
	endtask
	// offset then half gain on channel 1, negative offset on channel 2
	task automatic t_samples();
		logic [7:0] a [6] = '{8'h3c, 8'h40, 8'h44, 8'h48, 8'h50, 8'h54};
		logic [15:0] v [6] = '{16'h0001, 16'h0000, 16'h4000, 16'h0000, 16'hffff, 16'h0000};
		for (int i = 0; i < 6; i++)
			host.wr(a[i], {16'h0000, v[i]}, r);
		@(posedge aclk);
		ch1_sample_in   <= 24'h001000;
		ch2_sample_in   <= 24'h000400;
		sample_in_valid <= 1'b1;
		@(posedge aclk);
		sample_in_valid <= 1'b0;
		// result pulse stands for one cycle, two edges after the strobe
		@(posedge aclk);
		#1;
		chk(sample_out_valid, 1'b1);
		chk(ch1_sample_out, 24'h000880);
		chk(ch2_sample_out, 24'h000300);
		@(posedge aclk);
		#1;
		chk(sample_out_valid, 1'b0);
		chk(ch1_sample_out, 24'h000880);
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		{error_cnt, samples_checked} = '0;
		{aresetn, sample_in_valid, ch1_sample_in, ch2_sample_in, global_dc_filter_setting} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_mask();
		t_config();
		t_refuse();
		t_samples();
		summarize();
	end
	initial begin
		repeat (5000) @(posedge aclk);
		error_cnt++;
		summarize();
	end
endmodule
